// >>> rtl/pip_top.sv
/*
  peripheral interrupt prioritizer: ranks nmi, user break, level-coded pins and
  twelve peripheral requests, hands the winner to the cpu with its vector and
  table address. assumes peripheral and cpu signals on core_clk, pins async.
*/
// Design decisions made here: the address map and strobed register access.
// Operation
// R1 - each peripheral source owns its own vector
// R2 - per-module priority 0..15 in two registers
// R3 - accepted peripheral loads mask with its level
// R4 - table address is base plus vector times four
// R5 - pin levels fixed fifteen down to one
// R6 - fixed ranking inside a shared priority field
// R7 - reset sets every peripheral level to zero
// R8 - equal levels resolved by fixed default order
// R9 - pin auto-vectors 71..64, or external vector
// R10 - peripheral vectors from registers, 0..127
// R11 - priority fields at documented bit positions
// R12 - nmi level sixteen, always accepted
// R13 - level zero means masked
// R14 - external mode: level out, fetch strobe, read data
// R15 - accept only above current mask level
`timescale 1ns/10ps
`default_nettype none
`include "pip_consts.svh"

module pip_top
  import pip_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic core_ce,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic irq_out,
  input wire logic nmi_pin,
  input wire logic user_break_req,
  input wire logic [3:0] level_coded_request,
  input wire logic divider_overflow_request,
  input wire logic dma0_end_request,
  input wire logic dma1_end_request,
  input wire logic watchdog_interval_request,
  input wire logic refresh_compare_match_request,
  input wire logic receive_error_request,
  input wire logic receive_full_request,
  input wire logic transmit_empty_request,
  input wire logic transmit_end_request,
  input wire logic capture_request,
  input wire logic compare_request,
  input wire logic overflow_request,
  input wire logic [3:0] mask_level_bits,
  input wire logic cpu_accept,
  output logic cpu_irq_pending,
  output logic [4:0] cpu_irq_level,
  output logic vec_valid,
  output logic [7:0] vec_number,
  output logic [31:0] vec_table_addr,
  output logic mask_load,
  output logic [3:0] mask_level_new,
  output logic [3:0] accept_level_addr,
  output logic vector_fetch_strobe_n,
  input wire logic [7:0] ext_vector_data
);
  logic [15:0] prio_a_q, prio_b_q;
  logic [1:0] ctrl_q;
  logic [31:0] vbr_q;
  logic [6:0] vec_q [`PIP_NPER];
  logic [`PIP_ST_W-1:0] status_q, imask_q, st_set, st_clr;
  logic nmi_s, nmi_d1_q, nmi_edge, nmi_pend_q;
  logic [3:0] irl_s;
  logic [7:0] ext_s;
  logic [`PIP_NPER-1:0] per_req;
  pip_state_e state_q;
  logic [2:0] fetch_cnt_q;
  pip_lvl_t win_lvl;
  logic take, take_ext;
  pip_rank_if rk ();

  // software-visible decode of one peripheral's level
  function automatic logic [3:0] per_level(input int idx, input logic [15:0] a,
                                           input logic [15:0] b);
    logic [3:0] l;
    l = 4'h0;
    case (idx)
      0: l = a[`PIP_PA_DIV_LSB +: 4]; // R11
      1, 2: l = a[`PIP_PA_DMA_LSB +: 4]; // R11
      3, 4: l = a[`PIP_PA_WDT_LSB +: 4]; // R11
      5, 6, 7, 8: l = b[`PIP_PB_SCI_LSB +: 4]; // R11
      9, 10, 11: l = b[`PIP_PB_FRT_LSB +: 4]; // R11
      default: l = 4'h0;
    endcase
    return l;
  endfunction

  // vector of a winning source given its level
  function automatic pip_vec_t src_vector(input pip_idx_t idx, input pip_lvl_t lvl);
    pip_vec_t v;
    v = 8'h00;
    case (idx)
      `PIP_IDX_NMI: v = `PIP_VEC_NMI;
      `PIP_IDX_UB: v = `PIP_VEC_UB;
      `PIP_IDX_IRL: v = `PIP_VEC_IRL_BASE + {5'h00, lvl[3:1]}; // R9
      default: v = {1'b0, vec_q[idx - `PIP_IDX_PER0]}; // R1 R10
    endcase
    return v;
  endfunction

  pip_sync #(.W(1), .RST_VAL(1'b0)) u_nmi_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .core_ce(core_ce),
    .async_in(nmi_pin),
    .sync_out(nmi_s)
  );

  pip_sync #(.W(4), .RST_VAL(`PIP_IRL_IDLE)) u_irl_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .core_ce(core_ce),
    .async_in(level_coded_request),
    .sync_out(irl_s)
  );

  // data must settle two cycles before the fetch strobe rises
  pip_sync #(.W(8), .RST_VAL(8'h00)) u_ext_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .core_ce(core_ce),
    .async_in(ext_vector_data),
    .sync_out(ext_s)
  );

  assign per_req = {1'b0, overflow_request, compare_request, capture_request, // R6
                    transmit_end_request, transmit_empty_request,
                    receive_full_request, receive_error_request,
                    refresh_compare_match_request, watchdog_interval_request,
                    dma1_end_request, dma0_end_request, divider_overflow_request};

  // nmi edge detect on the synchronised level, edge chosen by control bit
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      nmi_d1_q <= 1'b0;
    end else if (core_ce) begin
      nmi_d1_q <= nmi_s;
    end
  end

  assign nmi_edge = ctrl_q[`PIP_CTRL_NMIE_BIT] ? (nmi_s && !nmi_d1_q) : (!nmi_s && nmi_d1_q);

  // a fresh edge in the accept cycle stays pending
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      nmi_pend_q <= 1'b0;
    end else if (core_ce) begin
      nmi_pend_q <= nmi_edge || (nmi_pend_q && !(take && rk.win == `PIP_IDX_NMI));
    end
  end

  // candidate list in default order; level zero and mask gate eligibility of all but nmi
  always_comb begin
    pip_lvl_t l;
    l = 5'h00;
    for (int i = 0; i < `PIP_NSRC; i++) begin
      if (i == 0) begin
        l = `PIP_LVL_NMI; // R12
      end else if (i == 1) begin
        l = user_break_req ? `PIP_LVL_UB : 5'h00;
      end else if (i == 2) begin
        l = {1'b0, ~irl_s}; // R5
      end else begin
        l = {1'b0, per_level(i - 3, prio_a_q, prio_b_q)}; // R2
      end
      rk.lvl[i] = l;
      if (i == 0) begin
        rk.req[i] = nmi_pend_q; // R12
      end else if (i < 3) begin
        rk.req[i] = (l != 5'h00) && (l > {1'b0, mask_level_bits}); // R13 R15
      end else begin
        rk.req[i] = per_req[i - 3] && (l != 5'h00) && (l > {1'b0, mask_level_bits}); // R13 R15
      end
    end
  end

  pip_rank u_rank (
    .rk(rk)
  );

  assign win_lvl = rk.lvl[rk.win];
  assign cpu_irq_pending = rk.found && (state_q == PIP_IDLE);
  assign cpu_irq_level = rk.found ? win_lvl : 5'h00;
  assign take = cpu_accept && cpu_irq_pending;
  assign take_ext = take && (rk.win == `PIP_IDX_IRL) && ctrl_q[`PIP_CTRL_VECTOR_MODE_SELECT_BIT];

  // accept sequence; one done cycle lets the cpu install its new mask
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_q <= PIP_IDLE;
      fetch_cnt_q <= 3'h0;
    end else if (core_ce) begin
      case (state_q)
        PIP_IDLE: begin
          if (take_ext) begin
            state_q <= PIP_FETCH;
            fetch_cnt_q <= 3'(`PIP_FETCH_CYC - 1);
          end else if (take) begin
            state_q <= PIP_DONE;
          end
        end
        PIP_FETCH: begin
          if (fetch_cnt_q == 3'h0) begin
            state_q <= PIP_DONE;
          end else begin
            fetch_cnt_q <= fetch_cnt_q - 3'h1;
          end
        end
        PIP_DONE: state_q <= PIP_IDLE;
        default: state_q <= PIP_IDLE;
      endcase
    end
  end

  // external vector pins: level out and strobe low through the fetch
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      accept_level_addr <= 4'h0;
      vector_fetch_strobe_n <= 1'b1;
    end else if (core_ce) begin
      if (take_ext) begin
        accept_level_addr <= win_lvl[3:0]; // R14
        vector_fetch_strobe_n <= 1'b0; // R14
      end else if (state_q == PIP_FETCH && fetch_cnt_q == 3'h0) begin
        vector_fetch_strobe_n <= 1'b1;
      end
    end
  end

  // answer to the cpu: vector, table entry and new mask level
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      vec_valid <= 1'b0;
      mask_load <= 1'b0;
      vec_number <= 8'h00;
      vec_table_addr <= 32'h0000_0000;
      mask_level_new <= 4'h0;
    end else if (core_ce) begin
      vec_valid <= 1'b0;
      mask_load <= 1'b0;
      if (take && !take_ext) begin
        vec_valid <= 1'b1;
        mask_load <= 1'b1;
        vec_number <= src_vector(rk.win, win_lvl);
        vec_table_addr <= vbr_q + {22'h00_0000, src_vector(rk.win, win_lvl), 2'b00}; // R4
        mask_level_new <= win_lvl[4] ? `PIP_MASK_TOP : win_lvl[3:0]; // R3
      end else if (state_q == PIP_FETCH && fetch_cnt_q == 3'h0) begin
        vec_valid <= 1'b1;
        mask_load <= 1'b1;
        vec_number <= ext_s; // R9 R14
        vec_table_addr <= vbr_q + {22'h00_0000, ext_s, 2'b00}; // R4
        mask_level_new <= accept_level_addr; // R3
      end
    end
  end

  // register writes
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      prio_a_q <= `PIP_PRIO_RST; // R7
      prio_b_q <= `PIP_PRIO_RST; // R7
      ctrl_q <= `PIP_CTRL_RST;
      vbr_q <= `PIP_VBR_RST;
      imask_q <= '0;
    end else if (core_ce && reg_wr) begin
      case (reg_addr)
        `PIP_OFS_PRIO_A: prio_a_q <= reg_wdata & `PIP_PRIO_A_WMASK; // R2 R11
        `PIP_OFS_PRIO_B: prio_b_q <= reg_wdata & `PIP_PRIO_B_WMASK; // R2 R11
        `PIP_OFS_CTRL: ctrl_q <= reg_wdata[1:0];
        `PIP_OFS_VBR_LO: vbr_q[15:0] <= reg_wdata;
        `PIP_OFS_VBR_HI: vbr_q[31:16] <= reg_wdata;
        `PIP_OFS_IMASK: imask_q <= reg_wdata[`PIP_ST_W-1:0];
        default: ;
      endcase
    end
  end

  // vector table: two 7-bit fields per register word, only the high field in the last word
  generate
    for (genvar k = 0; k < `PIP_NPER; k++) begin : g_vec
      localparam logic [3:0] OFS = 4'(`PIP_OFS_VEC0 + k / 2);
      localparam int LSB = (k % 2 == 0) ? `PIP_VEC_HI_LSB : `PIP_VEC_LO_LSB;
      always_ff @(posedge core_clk) begin
        if (sys_rst) begin
          vec_q[k] <= `PIP_VEC_RST;
        end else if (core_ce && reg_wr && reg_addr == OFS) begin
          vec_q[k] <= reg_wdata[LSB +: 7]; // R10
        end
      end
    end
  endgenerate

  // sticky events; a set in the clearing read wins
  always_comb begin
    st_set = '0;
    st_set[`PIP_ST_ACCEPT] = take;
    st_set[`PIP_ST_NMI] = nmi_edge;
    st_set[`PIP_ST_EXTFETCH] = take_ext;
    st_clr = (core_ce && reg_rd && reg_addr == `PIP_OFS_STATUS) ? '1 : '0;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      status_q <= '0;
    end else if (core_ce) begin
      status_q <= st_set | (status_q & ~st_clr);
    end
  end

  assign irq_out = |(status_q & imask_q);

  // read data one cycle after the strobe, zero elsewhere
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      reg_rdata <= 16'h0000;
    end else if (core_ce) begin
      reg_rdata <= 16'h0000;
      if (reg_rd) begin
        case (reg_addr)
          `PIP_OFS_PRIO_A: reg_rdata <= prio_a_q;
          `PIP_OFS_PRIO_B: reg_rdata <= prio_b_q;
          `PIP_OFS_CTRL: reg_rdata <= {14'h0000, ctrl_q};
          `PIP_OFS_VBR_LO: reg_rdata <= vbr_q[15:0];
          `PIP_OFS_VBR_HI: reg_rdata <= vbr_q[31:16];
          `PIP_OFS_STATUS: reg_rdata <= {13'h0000, status_q};
          `PIP_OFS_IMASK: reg_rdata <= {13'h0000, imask_q};
          default: begin
            if (reg_addr >= `PIP_OFS_VEC0 && reg_addr <= `PIP_OFS_VEC_LAST) begin
              reg_rdata <= {1'b0, vec_q[2 * (reg_addr - `PIP_OFS_VEC0)], 1'b0,
                            (reg_addr == `PIP_OFS_VEC_LAST) ? 7'h00
                            : vec_q[2 * (reg_addr - `PIP_OFS_VEC0) + 1]};
            end
          end
        endcase
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  AST_PRIO_RESET: assert property ($past(sys_rst) |-> prio_a_q == 16'h0000 && prio_b_q == 16'h0000) // R7
    else $error("priority registers not zero after reset");
  AST_PRIO_FIELD: assert property (core_ce && reg_wr && reg_addr == `PIP_OFS_PRIO_A
      |=> prio_a_q == ($past(reg_wdata) & 16'hFFF0)) // R11
    else $error("priority field write misplaced");
  AST_MASK_LOAD: assert property (core_ce && take && !take_ext && win_lvl < 5'h10
      |=> mask_load && mask_level_new == $past(win_lvl[3:0])) // R3
    else $error("mask not loaded with accepted level");
  AST_TABLE_ADDR: assert property (vec_valid |-> vec_table_addr == vbr_q + {22'h00_0000, vec_number, 2'b00}) // R4
    else $error("vector table address wrong");
  AST_NMI_FIRST: assert property (nmi_pend_q && state_q == PIP_IDLE
      |-> cpu_irq_pending && rk.win == `PIP_IDX_NMI && cpu_irq_level == 5'h10) // R12
    else $error("nmi not presented first");
  AST_ZERO_MASKED: assert property (cpu_irq_pending |-> cpu_irq_level != 5'h00) // R13
    else $error("level zero source presented");
  AST_ABOVE_MASK: assert property (cpu_irq_pending && rk.win != `PIP_IDX_NMI
      |-> cpu_irq_level > {1'b0, mask_level_bits}) // R15
    else $error("request not above mask presented");
  AST_PIN_LEVEL: assert property (rk.req[2] |-> rk.lvl[2] == 5'h0F - {1'b0, irl_s}) // R5
    else $error("pin level not fixed");
  AST_AUTOVEC: assert property (core_ce && take && !take_ext && rk.win == `PIP_IDX_IRL
      |=> vec_number == 8'h40 + {5'h00, $past(win_lvl[3:1])}) // R9
    else $error("auto-vector wrong");
  AST_DMA_ORDER: assert property (rk.req[4] && rk.req[5] |-> rk.win != 4'h5) // R6
    else $error("dma channel 1 beat channel 0");
  AST_EXT_FETCH: assert property (take_ext && core_ce
      |=> !vector_fetch_strobe_n [*4] ##1 vector_fetch_strobe_n && vec_valid) // R14
    else $error("external fetch strobe timing wrong");
  AST_PER_VEC: assert property (core_ce && take && rk.win >= `PIP_IDX_PER0
      |=> vec_number[7] == 1'b0 && vec_valid) // R10
    else $error("peripheral vector out of range");
  AST_NMI_ACCEPT: assert property (core_ce && take && rk.win == `PIP_IDX_NMI
      |=> vec_valid && vec_number == `PIP_VEC_NMI) // R12
    else $error("nmi accept not answered");

  COV_NMI: cover property (take && rk.win == `PIP_IDX_NMI);
  COV_EXT: cover property (take_ext ##5 vec_valid);
  COV_PER: cover property (take && rk.win == 4'h8);
endmodule

`default_nettype wire

// >>> rtl/pip_consts.svh
/*
  register offsets, field positions, reset values, fixed vectors and timing counts
  for the peripheral interrupt prioritizer; assumes a 125 MHz core clock.
*/
`ifndef PIP_CONSTS_SVH
`define PIP_CONSTS_SVH

`define PIP_NSRC 15
`define PIP_NPER 13
`define PIP_IDX_NMI 4'h0
`define PIP_IDX_UB 4'h1
`define PIP_IDX_IRL 4'h2
`define PIP_IDX_PER0 4'h3

`define PIP_OFS_PRIO_A 4'h0
`define PIP_OFS_PRIO_B 4'h1
`define PIP_OFS_CTRL 4'h2
`define PIP_OFS_VBR_LO 4'h3
`define PIP_OFS_VBR_HI 4'h4
`define PIP_OFS_VEC0 4'h5
`define PIP_OFS_VEC_LAST 4'hB
`define PIP_OFS_STATUS 4'hC
`define PIP_OFS_IMASK 4'hD

`define PIP_PA_DIV_LSB 12
`define PIP_PA_DMA_LSB 8
`define PIP_PA_WDT_LSB 4
`define PIP_PB_SCI_LSB 12
`define PIP_PB_FRT_LSB 8
`define PIP_VEC_HI_LSB 8
`define PIP_VEC_LO_LSB 0
`define PIP_PRIO_A_WMASK 16'hFFF0
`define PIP_PRIO_B_WMASK 16'hFF00

`define PIP_PRIO_RST 16'h0000
`define PIP_VEC_RST 7'h00
`define PIP_VBR_RST 32'h0000_0000
`define PIP_CTRL_RST 2'h0
`define PIP_CTRL_VECTOR_MODE_SELECT_BIT 0
`define PIP_CTRL_NMIE_BIT 1
`define PIP_IRL_IDLE 4'hF

`define PIP_ST_W 3
`define PIP_ST_ACCEPT 0
`define PIP_ST_NMI 1
`define PIP_ST_EXTFETCH 2

`define PIP_VEC_NMI 8'h0B
`define PIP_VEC_UB 8'h0C
`define PIP_VEC_IRL_BASE 8'h40
`define PIP_LVL_NMI 5'h10
`define PIP_LVL_UB 5'h0F
`define PIP_MASK_TOP 4'hF

`define PIP_CLK_NS 8
`define PIP_FETCH_NS 32
`define PIP_FETCH_CYC ((`PIP_FETCH_NS + `PIP_CLK_NS - 1) / `PIP_CLK_NS)

`endif

// >>> rtl/pip_pkg.sv
/*
  types of the peripheral interrupt prioritizer; assumes pip_consts.svh beside it.
*/
`include "pip_consts.svh"

package pip_pkg;
  typedef logic [4:0] pip_lvl_t;
  typedef logic [7:0] pip_vec_t;
  typedef logic [3:0] pip_idx_t;
  typedef enum logic [1:0] {
    PIP_IDLE = 2'b00,
    PIP_FETCH = 2'b01,
    PIP_DONE = 2'b11
  } pip_state_e;
endpackage

// >>> rtl/pip_rank_if.sv
/*
  carrier between the prioritizer core and its ranking module: eligible
  requests with their levels in, winning index out; assumes one clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
`include "pip_consts.svh"

interface pip_rank_if;
  import pip_pkg::*;
  logic [`PIP_NSRC-1:0] req;
  pip_lvl_t lvl [`PIP_NSRC];
  logic found;
  pip_idx_t win;
  modport src (output req, output lvl, input found, input win);
  modport rank (input req, input lvl, output found, output win);
endinterface

`default_nettype wire

// >>> rtl/pip_sync.sv
/*
  two-flop synchroniser for pin inputs; assumes core_clk domain, held by core_ce.
*/
`timescale 1ns/10ps
`default_nettype none

module pip_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic core_ce,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  // meta_q feeds only the second flop
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      meta_q <= RST_VAL;
      sync_out <= RST_VAL;
    end else if (core_ce) begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

`default_nettype wire

// >>> rtl/pip_rank.sv
/*
  picks the highest level among eligible requests; ties go to the lower index,
  which is the default order. assumes indexes are laid out in that order.
*/
`timescale 1ns/10ps
`default_nettype none
`include "pip_consts.svh"

module pip_rank
  import pip_pkg::*;
(
  pip_rank_if.rank rk
);
  always_comb begin
    pip_lvl_t best;
    best = 5'h00;
    rk.found = 1'b0;
    rk.win = 4'h0;
    for (int i = 0; i < `PIP_NSRC; i++) begin
      // strict compare keeps the earlier index on a tie
      if (rk.req[i] && (!rk.found || rk.lvl[i] > best)) begin // R8 R6
        rk.found = 1'b1;
        rk.win = 4'(i);
        best = rk.lvl[i];
      end
    end
  end
endmodule

`default_nettype wire

// >>> verif/pip_vec_src.sv
/*
  external vector source: answers a vector fetch on the low data lines.
  assumes the strobe and level lines of pip_top on core_clk.
*/
`timescale 1ns/10ps
`default_nettype none

module pip_vec_src #(
  parameter logic [7:0] VEC_BASE = 8'h20
) (
  input wire logic core_clk,
  input wire logic vector_fetch_strobe_n,
  input wire logic [3:0] accept_level_addr,
  output logic [7:0] ext_vector_data
);
  logic [7:0] vec_q = 8'h00;
  logic [7:0] idle_q = 8'h5A;
  logic held_q = 1'b0;
  logic [7:0] vec_d;

  assign vec_d = VEC_BASE + {4'h0, accept_level_addr};
  always_ff @(posedge core_clk) begin
    if (!vector_fetch_strobe_n) begin
      vec_q <= vec_d;
    end
    held_q <= !vector_fetch_strobe_n;
    // released bus toggles so a stale value cannot pass for a vector
    idle_q <= ~idle_q;
  end
  // one extra cycle of hold covers the two-flop sampling inside the device
  assign ext_vector_data = !vector_fetch_strobe_n ? vec_d : (held_q ? vec_q : idle_q);
endmodule

`default_nettype wire

// >>> verif/tb_top.sv
/*
  self-checking bench for pip_top: register and cpu accept tasks, scenarios.
  assumes pip_vec_src as the party that answers external vector fetches.
*/
`timescale 1ns/10ps
`default_nettype none
`include "pip_consts.svh"

module tb_top;
  import pip_pkg::*;
  localparam logic [7:0] EXT_BASE = 8'h20;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic core_ce = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic nmi_pin = 1'b0;
  logic user_break_req = 1'b0;
  logic [3:0] level_coded_request = 4'hF;
  logic [11:0] per_req = 12'h000;
  logic [3:0] mask_level_bits = 4'h0;
  logic cpu_accept = 1'b0;
  logic [15:0] reg_rdata;
  logic irq_out, cpu_irq_pending, vec_valid, mask_load, vector_fetch_strobe_n;
  logic [4:0] cpu_irq_level;
  logic [7:0] vec_number, ext_vector_data;
  logic [31:0] vec_table_addr;
  logic [3:0] mask_level_new, accept_level_addr;
  logic [31:0] vector_base_register = 32'h0001_2340;
  int srcs [5] = '{9, 5, 3, 1, 0};
  int fails = 0;
  int num_checks = 0;

  always #4 core_clk = ~core_clk;

  pip_top uut (.core_clk(core_clk), .sys_rst(sys_rst), .core_ce(core_ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq_out(irq_out), .nmi_pin(nmi_pin), .user_break_req(user_break_req),
    .level_coded_request(level_coded_request), .divider_overflow_request(per_req[0]),
    .dma0_end_request(per_req[1]), .dma1_end_request(per_req[2]),
    .watchdog_interval_request(per_req[3]), .refresh_compare_match_request(per_req[4]),
    .receive_error_request(per_req[5]), .receive_full_request(per_req[6]),
    .transmit_empty_request(per_req[7]), .transmit_end_request(per_req[8]),
    .capture_request(per_req[9]), .compare_request(per_req[10]),
    .overflow_request(per_req[11]), .mask_level_bits(mask_level_bits),
    .cpu_accept(cpu_accept), .cpu_irq_pending(cpu_irq_pending),
    .cpu_irq_level(cpu_irq_level), .vec_valid(vec_valid), .vec_number(vec_number),
    .vec_table_addr(vec_table_addr), .mask_load(mask_load), .mask_level_new(mask_level_new),
    .accept_level_addr(accept_level_addr), .vector_fetch_strobe_n(vector_fetch_strobe_n),
    .ext_vector_data(ext_vector_data));

  pip_vec_src #(.VEC_BASE(EXT_BASE)) vsrc (.core_clk(core_clk),
    .vector_fetch_strobe_n(vector_fetch_strobe_n), .accept_level_addr(accept_level_addr),
    .ext_vector_data(ext_vector_data));

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, exp);
    @(posedge core_clk);
  endtask

  task automatic quiet();
    #1;
    check(cpu_irq_pending, 1'b0);
    @(posedge core_clk);
  endtask

  // bounded wait: pin requests need the synchroniser delay first
  task automatic expect_pend(input logic [4:0] lvl);
    int n;
    n = 0;
    #1;
    while (cpu_irq_pending !== 1'b1 && n < 8) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    check(cpu_irq_pending, 1'b1);
    check(cpu_irq_level, lvl);
    @(posedge core_clk);
  endtask

  task automatic take(input logic [4:0] lvl, input logic [7:0] vec, input logic [3:0] msk,
                      input bit ext);
    int n;
    n = 0;
    expect_pend(lvl);
    cpu_accept <= 1'b1;
    @(posedge core_clk);
    cpu_accept <= 1'b0;
    #1;
    if (ext) begin
      check(vector_fetch_strobe_n, 1'b0);
      check(accept_level_addr, lvl[3:0]);
    end
    while (vec_valid !== 1'b1 && n < 8) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    check(n, ext ? `PIP_FETCH_CYC : 0);
    check(vec_valid, 1'b1);
    check(vector_fetch_strobe_n, 1'b1);
    check(mask_load, 1'b1);
    check(vec_number, vec);
    check(vec_table_addr, vector_base_register + {22'h0, vec, 2'b00});
    check(mask_level_new, msk);
    @(posedge core_clk);
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    summarize();
  end

  initial begin
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    rd(`PIP_OFS_PRIO_A, 16'h0000);
    rd(`PIP_OFS_PRIO_B, 16'h0000);
    per_req <= 12'hFFF;
    repeat (2) @(posedge core_clk);
    quiet();
    per_req <= 12'h000;
    wr(`PIP_OFS_PRIO_A, 16'hFFFF);
    rd(`PIP_OFS_PRIO_A, 16'hFFF0);
    wr(`PIP_OFS_PRIO_B, 16'hFFFF);
    rd(`PIP_OFS_PRIO_B, 16'hFF00);
    wr(`PIP_OFS_VEC0, 16'hFFFF);
    rd(`PIP_OFS_VEC0, 16'h7F7F);
    rd(4'hE, 16'h0000);
    wr(`PIP_OFS_VBR_LO, vector_base_register[15:0]);
    wr(`PIP_OFS_VBR_HI, vector_base_register[31:16]);
    rd(`PIP_OFS_VBR_HI, vector_base_register[31:16]);
    for (int k = 0; k < 6; k++) begin
      wr(`PIP_OFS_VEC0 + 4'(k), {1'b0, 7'(16 + 2 * k), 1'b0, 7'(17 + 2 * k)});
    end
    // equal levels everywhere: winners must come out in source order
    wr(`PIP_OFS_PRIO_A, 16'h3330);
    wr(`PIP_OFS_PRIO_B, 16'h3300);
    per_req <= 12'hFFF;
    for (int i = 0; i < 12; i++) begin
      take(5'h03, 8'(16 + i), 4'h3, 1'b0);
      per_req[i] <= 1'b0;
    end
    // distinct level per field: order follows the programmed levels
    wr(`PIP_OFS_PRIO_A, 16'h1230);
    wr(`PIP_OFS_PRIO_B, 16'h4500);
    per_req <= 12'h22B;
    for (int i = 0; i < 5; i++) begin
      take(5'(5 - i), 8'(16 + srcs[i]), 4'(5 - i), 1'b0);
      per_req[srcs[i]] <= 1'b0;
    end
    wr(`PIP_OFS_PRIO_A, 16'h5000);
    per_req <= 12'h001;
    mask_level_bits <= 4'h5;
    repeat (2) @(posedge core_clk);
    quiet();
    mask_level_bits <= 4'h4;
    take(5'h05, 8'h10, 4'h5, 1'b0);
    mask_level_bits <= 4'h0;
    level_coded_request <= 4'hA;
    repeat (4) @(posedge core_clk);
    take(5'h05, 8'h42, 4'h5, 1'b0);
    level_coded_request <= 4'hF;
    repeat (4) @(posedge core_clk);
    take(5'h05, 8'h10, 4'h5, 1'b0);
    per_req <= 12'h000;
    for (int v = 0; v < 15; v++) begin
      level_coded_request <= 4'(v);
      repeat (4) @(posedge core_clk);
      take(5'(15 - v), 8'(64 + (15 - v) / 2), 4'(15 - v), 1'b0);
    end
    level_coded_request <= 4'hF;
    user_break_req <= 1'b1;
    take(5'h0F, 8'h0C, 4'hF, 1'b0);
    user_break_req <= 1'b0;
    wr(`PIP_OFS_CTRL, 16'h0001);
    level_coded_request <= 4'h3;
    repeat (4) @(posedge core_clk);
    take(5'h0C, EXT_BASE + 8'h0C, 4'hC, 1'b1);
    level_coded_request <= 4'hF;
    repeat (4) @(posedge core_clk);
    wr(`PIP_OFS_CTRL, 16'h0002);
    #1;
    check(irq_out, 1'b0);
    @(posedge core_clk);
    rd(`PIP_OFS_STATUS, 16'h0005);
    wr(`PIP_OFS_IMASK, 16'h0002);
    mask_level_bits <= 4'hF;
    nmi_pin <= 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    check(irq_out, 1'b1);
    take(5'h10, 8'h0B, 4'hF, 1'b0);
    // falling-edge mode needs its own edge
    wr(`PIP_OFS_CTRL, 16'h0000);
    nmi_pin <= 1'b0;
    repeat (4) @(posedge core_clk);
    take(5'h10, 8'h0B, 4'hF, 1'b0);
    rd(`PIP_OFS_STATUS, 16'h0003);
    #1;
    check(irq_out, 1'b0);
    @(posedge core_clk);
    // enable low must freeze the registers
    core_ce <= 1'b0;
    wr(`PIP_OFS_PRIO_B, 16'h1100);
    core_ce <= 1'b1;
    rd(`PIP_OFS_PRIO_B, 16'h4500);
    // reset in mid-run clears programmed levels
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    rd(`PIP_OFS_PRIO_A, 16'h0000);
    summarize();
  end
endmodule

`default_nettype wire
